// [logic/cgrc_cfg.svh]
// Constants for the clock gate and reset control block
`ifndef CGRC_CFG_SVH
`define CGRC_CFG_SVH
`define CGRC_CPU_BASE 32'h4001_0000
`define CGRC_EXT_BASE 32'h000D_0000
`define CGRC_GATE_OFF 32'h0000_0000
`define CGRC_SWRST_OFF 32'h0000_0010
`define CGRC_GATE_RST_FB 32'h0000_6FDF
`define CGRC_GATE_RST_IS 32'h0000_2FFF
`define CGRC_WR_MASK 32'h0000_607F
`define CGRC_RSV_ONES 32'h0000_0F80
`define CGRC_ABSENT_FB 32'h0000_0020
`define CGRC_ABSENT_IS 32'h0000_4000
`define CGRC_ALL_ONES 32'hFFFF_FFFF
`define CGRC_ZERO 32'h0000_0000
`define CGRC_SWRST_BIT 0
`define CGRC_B_FB_SLAVE 14
`define CGRC_B_LEGACY_FB 13
`define CGRC_B_ETH_SW 6
`define CGRC_B_IND_SLAVE 5
`define CGRC_B_WDT 4
`define CGRC_B_CAN1 3
`define CGRC_B_CAN0 2
`define CGRC_B_SER1 1
`define CGRC_B_SER0 0
`define CGRC_RST_HOLD 16
`define CGRC_CLS_POR 0
`define CGRC_CLS_SYS 1
`define CGRC_CLS_HOT 2
`endif

// [logic/cgrc_pkg.sv]
// Types shared by the clock gate and reset control block
package cgrc_pkg;
  typedef enum logic [0:0] {
    CGRC_VAR_FIELDBUS = 1'h0,
    CGRC_VAR_INDUSTRIAL = 1'h1
  } cgrc_variant_t;
  typedef logic [2:0] cgrc_cls_t;
endpackage

// [logic/cgrc_rst_if.sv]
// Signals between register side and reset sequencer
`timescale 1ns/10ps
interface cgrc_rst_if;
  logic sw_req;
  logic wdt_req;
  logic chip_rst;
  logic pll_rst_n;
  logic rst_out_n;
  logic ram_init;
  modport ctl (input sw_req, input wdt_req, output chip_rst,
    output pll_rst_n, output rst_out_n, output ram_init);
  modport usr (output sw_req, output wdt_req, input chip_rst,
    input pll_rst_n, input rst_out_n, input ram_init);
endinterface

// [logic/cgrc_rst_seq.sv]
// Reset source synchroniser, stretcher and reset class outputs
`timescale 1ns/10ps
`include "cgrc_cfg.svh"
module cgrc_rst_seq #(
  parameter int RST_HOLD = `CGRC_RST_HOLD
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic power_on_reset_pin_n_i,
  input wire logic system_reset_pin_n_i,
  input wire logic hot_reset_pin_n_i,
  cgrc_rst_if.ctl rif
);
  localparam logic [7:0] HOLD = 8'(RST_HOLD);
  generate
    if (RST_HOLD < 1 || RST_HOLD > 255) begin : g_bad
      $error("RST_HOLD must be 1 to 255");
    end
  endgenerate

  cgrc_pkg::cgrc_cls_t pin_s1_r;
  cgrc_pkg::cgrc_cls_t pin_s2_r;
  cgrc_pkg::cgrc_cls_t req;
  cgrc_pkg::cgrc_cls_t nz;
  logic [7:0] cnt_r [3];
  logic [7:0] cnt_nxt [3];
  logic pll_rst_n_r;
  logic rst_out_n_r;
  logic ram_init_r;

  // Pins start asserted so the chip comes out of reset cleanly
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {hot_reset_pin_n_i, system_reset_pin_n_i,
                   power_on_reset_pin_n_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Software and watchdog requests join the hot class
  assign req[`CGRC_CLS_POR] = ~pin_s2_r[`CGRC_CLS_POR];
  assign req[`CGRC_CLS_SYS] = ~pin_s2_r[`CGRC_CLS_SYS];
  assign req[`CGRC_CLS_HOT] = ~pin_s2_r[`CGRC_CLS_HOT] | rif.sw_req |
                              rif.wdt_req;

  // Stretch keeps one-cycle requests long enough for the whole chip
  for (genvar k = 0; k < 3; k++) begin : g_cls
    assign cnt_nxt[k] = req[k] ? HOLD :
                        (cnt_r[k] != 8'h00) ? cnt_r[k] - 8'h01 : 8'h00;
    assign nz[k] = cnt_nxt[k] != 8'h00;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cnt_r[k] <= HOLD;
      end else begin
        cnt_r[k] <= cnt_nxt[k];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pll_rst_n_r <= 1'b0;
      rst_out_n_r <= 1'b0;
      ram_init_r <= 1'b1;
    end else begin
      pll_rst_n_r <= ~(nz[`CGRC_CLS_POR] | nz[`CGRC_CLS_SYS]);
      rst_out_n_r <= ~|nz;
      ram_init_r <= nz[`CGRC_CLS_POR];
    end
  end

  assign rif.pll_rst_n = pll_rst_n_r;
  assign rif.rst_out_n = rst_out_n_r;
  assign rif.chip_rst = ~rst_out_n_r;
  assign rif.ram_init = ram_init_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_por_ram;
    req[`CGRC_CLS_POR] |=> ram_init_r ##1 ram_init_r;
  endproperty
  a_por_ram: assert property (p_por_ram)
    else $error("power-on reset did not start RAM init");
  property p_no_ram;
    !req[`CGRC_CLS_POR] && cnt_r[`CGRC_CLS_POR] == 8'h00
      |=> !ram_init_r;
  endproperty
  a_no_ram: assert property (p_no_ram)
    else $error("RAM init without power-on reset");
  property p_hot_pll;
    (cnt_r[`CGRC_CLS_POR] == 8'h00 && cnt_r[`CGRC_CLS_SYS] == 8'h00 &&
     !req[`CGRC_CLS_POR] && !req[`CGRC_CLS_SYS]) |=> pll_rst_n_r;
  endproperty
  a_hot_pll: assert property (p_hot_pll)
    else $error("hot class reset touched the PLL");
  property p_out;
    (|req) |=> !rst_out_n_r [*2];
  endproperty
  a_out: assert property (p_out)
    else $error("reset output not driven low");
  property p_sw_hot;
    rif.sw_req |=> cnt_r[`CGRC_CLS_HOT] == HOLD && !rst_out_n_r;
  endproperty
  a_sw_hot: assert property (p_sw_hot)
    else $error("software reset not in hot class");
  property p_wdt;
    rif.wdt_req |=> !rst_out_n_r ##1 $past(cnt_r[`CGRC_CLS_HOT]) == HOLD;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog reset not taken");
  c_sw: cover property (rif.sw_req ##[1:300] rst_out_n_r);
  c_por: cover property ($fell(ram_init_r));
endmodule

// [logic/cgrc_top.sv]
// Peripheral clock gate register and reset control, two host paths
// Notes on behaviour
// - External host port sees the register area at base D_0000h.
// - Processor and DMA see the register area at base 4001_0000h.
// - Gate bits 31..15 are written zero and read back zero.
// - Gate bit 12 is written zero and read back zero.
// - Gate bits 11..7 are written one and read back one.
// - Bits 14,13,6,5 run fieldbus, legacy, switch, industrial slave.
// - Bits 4..0 run watchdog, CAN 1/0, serial 1/0; one means running.
// - Gate bit of a module absent in this variant reads zero.
// - A stopped clock stays stopped until a chip reset.
// - Reset value is 6FDFh or 2FFFh depending on the variant.
// - Power-on reset resets everything and initialises internal RAM.
// - Resets come from pins, software register and the watchdog.
// - Software reset behaves like the hot-reset pin.
// - Hot reset resets core and peripherals, leaves the PLL running.
// - Software and watchdog resets leave internal RAM alone.
// - Any internal reset drives the reset output pin low.
`timescale 1ns/10ps
`include "cgrc_cfg.svh"
module cgrc_top #(
  parameter cgrc_pkg::cgrc_variant_t VARIANT = cgrc_pkg::CGRC_VAR_FIELDBUS,
  parameter int RST_HOLD = `CGRC_RST_HOLD
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic cpu_sel_i,
  input wire logic cpu_wr_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic [31:0] cpu_wdata_i,
  output logic [31:0] cpu_rdata_o,
  input wire logic ext_sel_i,
  input wire logic ext_wr_i,
  input wire logic [19:0] ext_addr_i,
  input wire logic [31:0] ext_wdata_i,
  output logic [31:0] ext_rdata_o,
  input wire logic power_on_reset_pin_n_i,
  input wire logic system_reset_pin_n_i,
  input wire logic hot_reset_pin_n_i,
  input wire logic watchdog_reset_req_i,
  output logic reset_out_pin_n_o,
  output logic pll_reset_n_o,
  output logic ram_init_o,
  output logic gate_fieldbus_slave_o,
  output logic gate_legacy_fieldbus_o,
  output logic gate_eth_switch_o,
  output logic gate_industrial_slave_o,
  output logic gate_watchdog_o,
  output logic gate_can_unit1_o,
  output logic gate_can_unit0_o,
  output logic gate_serial_unit1_o,
  output logic gate_serial_unit0_o
);
  localparam logic [31:0] RST_VAL =
    (VARIANT == cgrc_pkg::CGRC_VAR_FIELDBUS) ?
    `CGRC_GATE_RST_FB : `CGRC_GATE_RST_IS;
  localparam logic [31:0] ABSENT =
    (VARIANT == cgrc_pkg::CGRC_VAR_FIELDBUS) ?
    `CGRC_ABSENT_FB : `CGRC_ABSENT_IS;
  localparam logic [31:0] KEEP = `CGRC_WR_MASK & ~ABSENT;

  function automatic logic cgrc_hit(input logic [31:0] a,
                                    input logic [31:0] base,
                                    input logic [31:0] off);
    return a == base + off;
  endfunction

  cgrc_rst_if rif ();
  cgrc_rst_seq #(.RST_HOLD(RST_HOLD)) u_seq (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .power_on_reset_pin_n_i(power_on_reset_pin_n_i),
    .system_reset_pin_n_i(system_reset_pin_n_i),
    .hot_reset_pin_n_i(hot_reset_pin_n_i),
    .rif(rif)
  );

  logic [31:0] gate_r;
  logic [31:0] gate_nxt;
  logic sw_req_r;
  logic sw_nxt;
  logic [31:0] cpu_rdata_r;
  logic [31:0] ext_rdata_r;

  wire [31:0] ext_addr = {12'h000, ext_addr_i};
  wire cpu_g = cgrc_hit(cpu_addr_i, `CGRC_CPU_BASE, `CGRC_GATE_OFF);
  wire cpu_s = cgrc_hit(cpu_addr_i, `CGRC_CPU_BASE, `CGRC_SWRST_OFF);
  wire ext_g = cgrc_hit(ext_addr, `CGRC_EXT_BASE, `CGRC_GATE_OFF);
  wire ext_s = cgrc_hit(ext_addr, `CGRC_EXT_BASE, `CGRC_SWRST_OFF);
  wire live = ~rif.chip_rst;
  wire cpu_gw = live & cpu_sel_i & cpu_wr_i & cpu_g;
  wire ext_gw = live & ext_sel_i & ext_wr_i & ext_g;
  wire cpu_sw = live & cpu_sel_i & cpu_wr_i & cpu_s &
                cpu_wdata_i[`CGRC_SWRST_BIT];
  wire ext_sw = live & ext_sel_i & ext_wr_i & ext_s &
                ext_wdata_i[`CGRC_SWRST_BIT];

  // Writes can only clear gate bits; both paths share one register
  wire [31:0] cpu_and = cpu_gw ? cpu_wdata_i : `CGRC_ALL_ONES;
  wire [31:0] ext_and = ext_gw ? ext_wdata_i : `CGRC_ALL_ONES;
  assign gate_nxt = rif.chip_rst ? (RST_VAL & KEEP) :
                    gate_r & cpu_and & ext_and & KEEP;
  assign sw_nxt = ~rif.chip_rst & (sw_req_r | cpu_sw | ext_sw);

  // Reserved fields are built into the read value, never stored
  wire [31:0] gate_rd = (gate_r & KEEP) | `CGRC_RSV_ONES;
  wire [31:0] sw_rd = {31'h0000_0000, sw_req_r};
  wire [31:0] cpu_rd_nxt = !(cpu_sel_i && !cpu_wr_i) ? `CGRC_ZERO :
                           cpu_g ? gate_rd : cpu_s ? sw_rd : `CGRC_ZERO;
  wire [31:0] ext_rd_nxt = !(ext_sel_i && !ext_wr_i) ? `CGRC_ZERO :
                           ext_g ? gate_rd : ext_s ? sw_rd : `CGRC_ZERO;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate_r <= RST_VAL & KEEP;
      sw_req_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
      sw_req_r <= sw_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cpu_rdata_r <= `CGRC_ZERO;
      ext_rdata_r <= `CGRC_ZERO;
    end else begin
      cpu_rdata_r <= cpu_rd_nxt;
      ext_rdata_r <= ext_rd_nxt;
    end
  end

  assign rif.sw_req = sw_req_r;
  assign rif.wdt_req = watchdog_reset_req_i;
  assign cpu_rdata_o = cpu_rdata_r;
  assign ext_rdata_o = ext_rdata_r;
  assign reset_out_pin_n_o = rif.rst_out_n;
  assign pll_reset_n_o = rif.pll_rst_n;
  assign ram_init_o = rif.ram_init;
  // A host touching a stopped unit is its own fault; no blocking here
  assign gate_fieldbus_slave_o = gate_r[`CGRC_B_FB_SLAVE];
  assign gate_legacy_fieldbus_o = gate_r[`CGRC_B_LEGACY_FB];
  assign gate_eth_switch_o = gate_r[`CGRC_B_ETH_SW];
  assign gate_industrial_slave_o = gate_r[`CGRC_B_IND_SLAVE];
  assign gate_watchdog_o = gate_r[`CGRC_B_WDT];
  assign gate_can_unit1_o = gate_r[`CGRC_B_CAN1];
  assign gate_can_unit0_o = gate_r[`CGRC_B_CAN0];
  assign gate_serial_unit1_o = gate_r[`CGRC_B_SER1];
  assign gate_serial_unit0_o = gate_r[`CGRC_B_SER0];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  wire cpu_grd = cpu_sel_i & ~cpu_wr_i & cpu_g;
  wire ext_grd = ext_sel_i & ~ext_wr_i & ext_g;
  property p_ext_base;
    ext_gw && !ext_wdata_i[0] |=> !gate_serial_unit0_o;
  endproperty
  a_ext_base: assert property (p_ext_base)
    else $error("external path write to gate missed");
  property p_cpu_base;
    cpu_gw && !cpu_wdata_i[1] |=> !gate_serial_unit1_o;
  endproperty
  a_cpu_base: assert property (p_cpu_base)
    else $error("processor path write to gate missed");
  property p_hi_zero;
    cpu_grd |=> cpu_rdata_o[31:15] == 17'h0_0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("gate bits 31..15 not zero");
  property p_b12;
    ext_grd |=> !ext_rdata_o[12];
  endproperty
  a_b12: assert property (p_b12)
    else $error("gate bit 12 not zero");
  property p_ones;
    cpu_grd |=> cpu_rdata_o[11:7] == 5'h1F;
  endproperty
  a_ones: assert property (p_ones)
    else $error("gate bits 11..7 not one");
  property p_units;
    cpu_gw && !cpu_wdata_i[6] && !cpu_wdata_i[4] |=>
      !gate_eth_switch_o && !gate_watchdog_o [*2];
  endproperty
  a_units: assert property (p_units)
    else $error("stopped unit clock still running");
  property p_absent;
    (gate_r & ABSENT) == `CGRC_ZERO;
  endproperty
  a_absent: assert property (p_absent)
    else $error("absent module gate bit set");
  property p_sticky;
    !rif.chip_rst |=> (gate_r & ~$past(gate_r)) == `CGRC_ZERO;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("stopped clock restarted without reset");
  property p_rst_val;
    rif.chip_rst |=> gate_r == (RST_VAL & KEEP);
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("gate reset value wrong");
  property p_shared;
    ext_gw && !ext_wdata_i[2] ##1 cpu_grd |=> !cpu_rdata_o[2];
  endproperty
  a_shared: assert property (p_shared)
    else $error("paths see different gate registers");
  property p_absent_rd;
    ext_grd |=> (ext_rdata_o & ABSENT) == `CGRC_ZERO;
  endproperty
  a_absent_rd: assert property (p_absent_rd)
    else $error("absent module gate bit read as one");
  property p_sw_out;
    rif.sw_req |=> !reset_out_pin_n_o;
  endproperty
  a_sw_out: assert property (p_sw_out)
    else $error("software reset did not drive reset output");
  c_stop: cover property (cpu_gw ##1 $fell(gate_can_unit0_o));
  c_ext_rd: cover property (ext_grd);
  c_sw: cover property (ext_sw ##[1:5] !reset_out_pin_n_o);
endmodule

// [verification/cgrc_tb_top.sv]
// Self-checking testbench for the clock gate and reset control block
`timescale 1ns/10ps
`include "cgrc_cfg.svh"
module cgrc_tb_top;
  localparam logic [31:0] CG = `CGRC_CPU_BASE + `CGRC_GATE_OFF;
  localparam logic [31:0] EG = `CGRC_EXT_BASE + `CGRC_GATE_OFF;
  localparam logic [31:0] RV = `CGRC_GATE_RST_FB & ~`CGRC_ABSENT_FB;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cs = 1'b0, cw = 1'b0, es = 1'b0, ew = 1'b0;
  logic [31:0] ca = '0, cd = '0, ed = '0, crd, erd;
  logic [19:0] ea = '0;
  logic por_n = 1'b1, sys_n = 1'b1, hot_n = 1'b1, wdt = 1'b0;
  logic rst_out_n, pll_n, ram_init;
  wire [8:0] gates;
  int miscompares = 0;
  int n_checks = 0;

  cgrc_top #(.VARIANT(cgrc_pkg::CGRC_VAR_FIELDBUS), .RST_HOLD(2)) u_cgrc_top (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .cpu_sel_i(cs), .cpu_wr_i(cw), .cpu_addr_i(ca), .cpu_wdata_i(cd),
    .cpu_rdata_o(crd), .ext_sel_i(es), .ext_wr_i(ew), .ext_addr_i(ea),
    .ext_wdata_i(ed), .ext_rdata_o(erd),
    .power_on_reset_pin_n_i(por_n), .system_reset_pin_n_i(sys_n),
    .hot_reset_pin_n_i(hot_n), .watchdog_reset_req_i(wdt),
    .reset_out_pin_n_o(rst_out_n), .pll_reset_n_o(pll_n),
    .ram_init_o(ram_init),
    .gate_fieldbus_slave_o(gates[8]), .gate_legacy_fieldbus_o(gates[7]),
    .gate_eth_switch_o(gates[6]), .gate_industrial_slave_o(gates[5]),
    .gate_watchdog_o(gates[4]), .gate_can_unit1_o(gates[3]),
    .gate_can_unit0_o(gates[2]), .gate_serial_unit1_o(gates[1]),
    .gate_serial_unit0_o(gates[0]));

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; sel is held across the taking edge, data read after it
  task automatic acc(input logic ext, input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(negedge sys_clk_i);
    if (ext) begin
      es = 1'b1;
      ew = wr;
      ea = a[19:0];
      ed = d;
    end else begin
      cs = 1'b1;
      cw = wr;
      ca = a;
      cd = d;
    end
    @(negedge sys_clk_i);
    cs = 1'b0;
    es = 1'b0;
    q = ext ? erd : crd;
  endtask

  task automatic wait_rst(input logic lvl);
    int i;
    i = 0;
    while (rst_out_n !== lvl && i < 60) begin
      @(negedge sys_clk_i);
      i++;
    end
    chk({31'h0, rst_out_n}, {31'h0, lvl});
  endtask

  // Same register seen from both paths and on the run enables
  task automatic chk_gate(input logic [31:0] v);
    logic [31:0] q;
    acc(1'b0, 1'b0, CG, '0, q);
    chk(q, v);
    acc(1'b1, 1'b0, EG, '0, q);
    chk(q, v);
    chk({23'h0, gates}, {23'h0, v[14:13], v[6:0]});
  endtask

  task automatic t_regs();
    logic [31:0] q, v1, v2;
    v1 = RV & ~32'h0000_0001;
    v2 = v1 & ~32'h0000_2040;
    chk_gate(RV);
    acc(1'b0, 1'b1, CG, RV, q);
    chk_gate(RV);
    acc(1'b0, 1'b1, CG, v1, q);
    chk_gate(v1);
    acc(1'b1, 1'b1, EG, v2, q);
    chk_gate(v2);
    acc(1'b0, 1'b1, CG, RV, q);
    chk_gate(v2);
    acc(1'b0, 1'b0, CG + 32'h0000_0004, '0, q);
    chk(q, `CGRC_ZERO);
    acc(1'b0, 1'b0, `CGRC_EXT_BASE, '0, q);
    chk(q, `CGRC_ZERO);
    acc(1'b1, 1'b0, `CGRC_CPU_BASE, '0, q);
    chk(q, `CGRC_ZERO);
    acc(1'b1, 1'b1, EG + 32'h0000_0004, `CGRC_ZERO, q);
    chk_gate(v2);
  endtask

  // Both paths write in one cycle, processor reads back on the next
  task automatic t_shared();
    @(negedge sys_clk_i);
    cs = 1'b1;
    cw = 1'b1;
    ca = CG;
    cd = RV & ~32'h0000_0050;
    es = 1'b1;
    ew = 1'b1;
    ea = EG[19:0];
    ed = RV & ~32'h0000_0004;
    @(negedge sys_clk_i);
    cw = 1'b0;
    es = 1'b0;
    @(negedge sys_clk_i);
    cs = 1'b0;
    chk(crd, RV & ~32'h0000_2055);
    chk_gate(RV & ~32'h0000_2055);
  endtask

  // Source 0 power-on, 1 system, 2 hot, 3 watchdog, 4 software
  task automatic t_reset(input int src, input logic epll, input logic eram);
    logic [31:0] q;
    // Watchdog kept running so that its request is a genuine one
    acc(1'b0, 1'b1, CG, RV & ~32'h0000_0005, q);
    if (src == 4) begin
      acc(1'b0, 1'b1, `CGRC_CPU_BASE + `CGRC_SWRST_OFF, 32'h0000_0001, q);
    end else begin
      @(negedge sys_clk_i);
      por_n = (src != 0);
      sys_n = (src != 1);
      hot_n = (src != 2);
      wdt = (src == 3);
    end
    wait_rst(1'b0);
    @(negedge sys_clk_i);
    chk({31'h0, pll_n}, {31'h0, epll});
    chk({31'h0, ram_init}, {31'h0, eram});
    por_n = 1'b1;
    sys_n = 1'b1;
    hot_n = 1'b1;
    wdt = 1'b0;
    wait_rst(1'b1);
    chk_gate(RV);
  endtask

  initial begin
    #(4000 * 50);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    wait_rst(1'b1);
    t_regs();
    t_shared();
    t_reset(4, 1'b1, 1'b0);
    t_reset(3, 1'b1, 1'b0);
    t_reset(2, 1'b1, 1'b0);
    t_reset(1, 1'b0, 1'b0);
    t_reset(0, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule
